// file: design/cvt_pkg.sv
// Package of constants and types for the character video timing generator.
package cvt_pkg;

  // ************************************************************
  // Dot clock divider and line counters
  // ************************************************************
  localparam logic [3:0] CVT_DOT_START = 4'h7;
  localparam logic [3:0] CVT_DOT_LAST = 4'hf;
  localparam logic [3:0] CVT_POS_PRESET = 4'h3;
  localparam logic [3:0] CVT_SUB_WRAP = 4'hf;
  localparam logic [3:0] CVT_GROUP_LAST = 4'h9;
  localparam logic [3:0] CVT_SUB_LAST = 4'h8;
  localparam logic [3:0] CVT_SCAN_BLANK = 4'hf;
  localparam logic [3:0] CVT_SCAN_LAST = 4'hb;
  localparam logic [3:0] CVT_ROW_ACTIVE_START = 4'h0;
  localparam logic [3:0] CVT_ROW_BLANK_START = 4'hc;
  localparam logic [3:0] CVT_ROW_LAST = 4'hf;
  localparam logic [6:0] CVT_SPACE_CODE = 7'h20;

  // ************************************************************
  // Register map (byte addresses) and reset values
  // ************************************************************
  localparam logic [4:0] CVT_OFS_CTRL = 5'h00;
  localparam logic [4:0] CVT_OFS_HSYNC = 5'h04;
  localparam logic [4:0] CVT_OFS_VSYNC = 5'h08;
  localparam logic [4:0] CVT_OFS_STATUS = 5'h0c;
  localparam int CVT_CTRL_CCB_BIT = 0;
  localparam int CVT_CTRL_REV_BIT = 1;
  localparam int CVT_CTRL_SHADE_LSB = 4;
  localparam logic [31:0] CVT_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CVT_HSYNC_RESET = 32'h0044_0008;
  localparam logic [31:0] CVT_VSYNC_RESET = 32'h0800_0010;

  // Sync one-shot states, Gray coded along idle, delay, pulse.
  typedef enum logic [1:0] {
    CVT_OS_IDLE = 2'b00,
    CVT_OS_DELAY = 2'b01,
    CVT_OS_PULSE = 2'b11
  } cvt_os_state_t;

endpackage : cvt_pkg

// file: design/cvt_timing_gen.sv
// Video timing, address selection, sync and blanking for a 64 by 16 character display.
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/100ps
// Functional notes
// R01: Each scan line starts by loading 3 into subgroup and group counters.
// R02: Subgroup counts each character, 3..15 then 0..15; wraps advance group.
// R03: Group 9 with subgroup 8 reloads 3; line is 102 characters.
// R04: Group bit 3 is the hsync trigger, group bit 2 horizontal visible.
// R05: Column address is four subgroup bits plus two low group bits.
// R06: Bus address selected when page selected and mid-sync phase rises, held.
// R07: Scan counter holds 15 on first line, then counts 0..11.
// R08: Scan count 11 at a line preset reloads 15.
// R09: Scan line 15 always produces blank dots; the code loads zeros there, but a set cursor bit still inverts them.
// R10: Row-overflow enable fires once per character row, advancing the row counter.
// R11: Row counter carry reloads 12 when vertical visible low, 0 when high.
// R12: Carry at 15 toggles vertical visible and loads the row counter.
// R13: Frame holds 16 active and 4 blanked rows of 13 lines.
// R14: Hsync and vsync are pulses of adjustable width with adjustable start delay.
// R15: Composite sync is hsync XOR vsync.
// R16: Control codes with option set load zeros into the dot serializer.
// R17: Shade or composite blanking forces video to the option's blank level.
// R18: Vertical visible sets shade blank; chosen row 0..15 clears it.
// R19: Composite blank is delayed two character loads and is active low.
// R20: Dot clock divided by nine with a counter running 7..15.
// R21: Character load pulse is low for one dot clock per character.
// R22: Sync widths and delays are configurable dot-clock counts.
module cvt_timing_gen
  import cvt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:2] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic display_page_select_n_i,
  input wire logic mid_sync_phase_i,
  input wire logic [9:0] ext_addr_i,
  input wire logic [7:0] char_data_i,
  input wire logic [6:0] glyph_i,
  output logic [9:0] mem_addr_o,
  output logic [6:0] char_code_o,
  output logic [3:0] scan_line_o,
  output logic load_clock_n_o,
  output logic hsync_trigger_o,
  output logic horizontal_visible_o,
  output logic vertical_visible_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic comp_sync_o,
  output logic comp_blank_n_o,
  output logic video_o
);

  // ************************************************************
  // Register slave
  // ************************************************************
  logic [31:0] ctrl_q, hsync_cfg_q, vsync_cfg_q;
  logic ack_q;
  logic [4:0] byte_adr;
  logic bus_req, wr_ctrl, wr_hsync, wr_vsync;
  logic [31:0] status_word, rd_word;
  logic ctrl_char_blank_option, reverse_video_option;
  logic [3:0] shade_end_row;

  // Merge write data into an old value under the byte enables.
  function automatic logic [31:0] cvt_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : cvt_merge

  // Address decode; unmapped addresses read zero and ignore writes, but are acknowledged.
  assign byte_adr = {wb_adr_i, 2'b00};
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_ctrl = bus_req && wb_we_i && (byte_adr == CVT_OFS_CTRL);
  assign wr_hsync = bus_req && wb_we_i && (byte_adr == CVT_OFS_HSYNC);
  assign wr_vsync = bus_req && wb_we_i && (byte_adr == CVT_OFS_VSYNC);
  assign ctrl_char_blank_option = ctrl_q[CVT_CTRL_CCB_BIT];
  assign reverse_video_option = ctrl_q[CVT_CTRL_REV_BIT];
  assign shade_end_row = ctrl_q[CVT_CTRL_SHADE_LSB +: 4];

  always_comb begin
    if (byte_adr == CVT_OFS_CTRL) begin
      rd_word = ctrl_q;
    end else if (byte_adr == CVT_OFS_HSYNC) begin
      rd_word = hsync_cfg_q;
    end else if (byte_adr == CVT_OFS_VSYNC) begin
      rd_word = vsync_cfg_q;
    end else if (byte_adr == CVT_OFS_STATUS) begin
      rd_word = status_word;
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  // One wait state: ack rises the cycle after the request and drops the next.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CVT_CTRL_RESET;
      hsync_cfg_q <= CVT_HSYNC_RESET;
      vsync_cfg_q <= CVT_VSYNC_RESET;
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      wb_dat_o <= bus_req ? rd_word : 32'h0000_0000;
      if (wr_ctrl) begin
        ctrl_q <= cvt_merge(ctrl_q, wb_dat_i, wb_sel_i);
      end
      if (wr_hsync) begin
        hsync_cfg_q <= cvt_merge(hsync_cfg_q, wb_dat_i, wb_sel_i);
      end
      if (wr_vsync) begin
        vsync_cfg_q <= cvt_merge(vsync_cfg_q, wb_dat_i, wb_sel_i);
      end
    end
  end
  assign wb_ack_o = ack_q;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [11:0] pin_meta_q, pin_sync_q;
  logic page_sel_n_s, mid_phase_s, mid_phase_d1_q;
  logic [9:0] ext_addr_s;

  // The address pins are only used while the page select holds them steady.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= 12'hfff;
      pin_sync_q <= 12'hfff;
      mid_phase_d1_q <= 1'b1;
    end else begin
      pin_meta_q <= {display_page_select_n_i, mid_sync_phase_i, ext_addr_i};
      pin_sync_q <= pin_meta_q;
      mid_phase_d1_q <= mid_phase_s;
    end
  end
  assign page_sel_n_s = pin_sync_q[11];
  assign mid_phase_s = pin_sync_q[10];
  assign ext_addr_s = pin_sync_q[9:0];

  // ************************************************************
  // Dot divider and character timing
  // ************************************************************
  logic [3:0] dot_q, sub_q, grp_q, scan_q, row_q;
  logic char_tick, line_tick, row_ovf, row_carry, vvis_q, load_n_q;

  // Running 7..15 gives nine dots per character; the load pulse is the last dot.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dot_q <= CVT_DOT_START;
      load_n_q <= 1'b1;
    end else begin
      dot_q <= (dot_q == CVT_DOT_LAST) ? CVT_DOT_START : dot_q + 4'h1; // R20
      load_n_q <= (dot_q != (CVT_DOT_LAST - 4'h1)); // R21
    end
  end
  assign char_tick = (dot_q == CVT_DOT_LAST);
  assign load_clock_n_o = load_n_q;

  // Line preset, row overflow and row carry decodes.
  assign line_tick = char_tick && (grp_q == CVT_GROUP_LAST) && (sub_q == CVT_SUB_LAST); // R03
  assign row_ovf = line_tick && (scan_q == CVT_SCAN_LAST); // R10
  assign row_carry = row_ovf && (row_q == CVT_ROW_LAST);

  // Horizontal position counters.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_q <= CVT_POS_PRESET;
      grp_q <= CVT_POS_PRESET;
    end else if (line_tick) begin
      sub_q <= CVT_POS_PRESET; // R01
      grp_q <= CVT_POS_PRESET; // R01
    end else if (char_tick) begin
      sub_q <= sub_q + 4'h1; // R02
      if (sub_q == CVT_SUB_WRAP) begin
        grp_q <= grp_q + 4'h1; // R02
      end
    end
  end
  assign hsync_trigger_o = grp_q[3]; // R04
  assign horizontal_visible_o = grp_q[2]; // R04

  // Scan line counter: 15 for the spacer line, then 0..11, giving 13 lines per row.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_q <= CVT_SCAN_BLANK;
    end else if (row_ovf) begin
      scan_q <= CVT_SCAN_BLANK; // R08
    end else if (line_tick) begin
      scan_q <= scan_q + 4'h1; // R07
    end
  end
  assign scan_line_o = scan_q;

  // Row counter and vertical visible flag; the load uses the flag's old value,
  // so 16 active rows alternate with 4 blanked rows.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      row_q <= CVT_ROW_ACTIVE_START;
      vvis_q <= 1'b0;
    end else if (row_carry) begin
      vvis_q <= !vvis_q; // R12
      row_q <= vvis_q ? CVT_ROW_ACTIVE_START : CVT_ROW_BLANK_START; // R11 R13
    end else if (row_ovf) begin
      row_q <= row_q + 4'h1; // R10
    end
  end
  assign vertical_visible_o = vvis_q;

  // ************************************************************
  // Display memory address selection
  // ************************************************************
  logic ext_sel_q;
  logic [9:0] mem_addr_q;

  // Bus side takes the memory from mid-sync until page select is released.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_sel_q <= 1'b0;
      mem_addr_q <= 10'h000;
    end else begin
      if (page_sel_n_s) begin
        ext_sel_q <= 1'b0;
      end else if (mid_phase_s && !mid_phase_d1_q) begin
        ext_sel_q <= 1'b1; // R06
      end
      mem_addr_q <= ext_sel_q ? ext_addr_s : {row_q, grp_q[1:0], sub_q}; // R05 R06
    end
  end
  assign mem_addr_o = mem_addr_q;

  // ************************************************************
  // Character latch and dot serializer
  // ************************************************************
  logic [7:0] char_q;
  logic [8:0] shift_q;
  logic cursor_q, ctrl_code, clear_dots;

  // A bus access clears the latch to a space so the cell shows blank.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      char_q <= {1'b0, CVT_SPACE_CODE};
    end else if (ext_sel_q) begin
      char_q <= {1'b0, CVT_SPACE_CODE};
    end else if (char_tick) begin
      char_q <= char_data_i;
    end
  end
  assign char_code_o = char_q[6:0];
  assign ctrl_code = (char_q[6:5] == 2'b00);
  assign clear_dots = (ctrl_char_blank_option && ctrl_code) || (scan_q == CVT_SCAN_BLANK);

  // Seven glyph dots then two spacer dots; the cursor bit travels with the cell.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= 9'h000;
      cursor_q <= 1'b0;
    end else if (!load_n_q) begin
      shift_q <= clear_dots ? 9'h000 : {glyph_i, 2'b00}; // R09 R16
      cursor_q <= char_q[7];
    end else begin
      shift_q <= {shift_q[7:0], 1'b0};
    end
  end

  // ************************************************************
  // Blanking
  // ************************************************************
  logic shade_q;
  logic [1:0] blank_pipe_q;
  logic comp_blank_raw, blank_now, video_q;

  // Shade starts with vertical blanking and ends at the chosen active row.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shade_q <= 1'b1;
    end else if (vvis_q) begin
      shade_q <= 1'b1; // R18
    end else if (row_q == shade_end_row) begin
      shade_q <= 1'b0; // R18
    end
  end

  // Delay blanking two character loads to line up with the memory pipeline.
  assign comp_blank_raw = !grp_q[2] || vvis_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blank_pipe_q <= 2'b11;
    end else if (!load_n_q) begin
      blank_pipe_q <= {blank_pipe_q[0], comp_blank_raw}; // R19
    end
  end
  assign comp_blank_n_o = !blank_pipe_q[1]; // R19

  assign blank_now = shade_q || blank_pipe_q[1];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      video_q <= 1'b0;
    end else if (blank_now) begin
      video_q <= reverse_video_option; // R17
    end else begin
      video_q <= shift_q[8] ^ cursor_q ^ reverse_video_option;
    end
  end
  assign video_o = video_q;

  // ************************************************************
  // Sync one-shots
  // ************************************************************
  logic grp3_d1_q, vvis_d1_q, hsync_rise, vsync_rise;
  logic [1:0] os_trig;
  logic [31:0] os_cfg [2];
  cvt_os_state_t os_q [2];
  logic [15:0] os_cnt_q [2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grp3_d1_q <= 1'b0;
      vvis_d1_q <= 1'b0;
    end else begin
      grp3_d1_q <= grp_q[3];
      vvis_d1_q <= vvis_q;
    end
  end
  assign hsync_rise = grp_q[3] && !grp3_d1_q; // R14
  assign vsync_rise = vvis_q && !vvis_d1_q; // R14
  assign os_trig = {vsync_rise, hsync_rise};
  assign os_cfg[0] = hsync_cfg_q;
  assign os_cfg[1] = vsync_cfg_q;

  // Delay counts delay+1 cycles, then the pulse lasts width cycles (0 acts as 1).
  // A trigger during a running pulse is ignored, as a one-shot would.
  for (genvar g = 0; g < 2; g++) begin : g_oneshot
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        os_q[g] <= CVT_OS_IDLE;
        os_cnt_q[g] <= 16'h0000;
      end else begin
        case (os_q[g])
          CVT_OS_IDLE: begin
            if (os_trig[g]) begin
              os_q[g] <= CVT_OS_DELAY;
              os_cnt_q[g] <= os_cfg[g][15:0]; // R22
            end
          end
          CVT_OS_DELAY: begin
            if (os_cnt_q[g] == 16'h0000) begin
              os_q[g] <= CVT_OS_PULSE;
              os_cnt_q[g] <= (os_cfg[g][31:16] == 16'h0000) ? 16'h0000
                             : os_cfg[g][31:16] - 16'h0001; // R22
            end else begin
              os_cnt_q[g] <= os_cnt_q[g] - 16'h0001;
            end
          end
          CVT_OS_PULSE: begin
            if (os_cnt_q[g] == 16'h0000) begin
              os_q[g] <= CVT_OS_IDLE;
            end else begin
              os_cnt_q[g] <= os_cnt_q[g] - 16'h0001;
            end
          end
          default: begin
            os_q[g] <= CVT_OS_IDLE;
          end
        endcase
      end
    end
  end
  assign hsync_o = (os_q[0] == CVT_OS_PULSE); // R14
  assign vsync_o = (os_q[1] == CVT_OS_PULSE); // R14
  assign comp_sync_o = hsync_o ^ vsync_o; // R15

  assign status_word = {14'h0000, vvis_q, shade_q, row_q, scan_q, grp_q, sub_q};

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_load_gap;
    load_clock_n_o [*8] ##1 !load_clock_n_o;
  endsequence

  a_dot_wrap: assert property (dot_q == CVT_DOT_LAST |=> dot_q == CVT_DOT_START) // R20
    else $error("dot divider did not restart at 7");
  a_load_spacing: assert property ($fell(load_clock_n_o) |=> s_load_gap) // R21
    else $error("load pulse not one dot in nine");
  a_line_preset: assert property (line_tick |=> sub_q == CVT_POS_PRESET && grp_q == CVT_POS_PRESET) // R03
    else $error("line preset did not load 3");
  a_sub_carry: assert property (char_tick && !line_tick && sub_q == CVT_SUB_WRAP
    |=> sub_q == 4'h0 && grp_q == $past(grp_q) + 4'h1) // R02
    else $error("subgroup wrap did not advance group");
  a_scan_step: assert property (line_tick && scan_q != CVT_SCAN_LAST
    |=> scan_q == $past(scan_q) + 4'h1) // R07
    else $error("scan counter did not step");
  a_scan_reload: assert property (row_ovf |=> scan_q == CVT_SCAN_BLANK) // R08
    else $error("scan counter did not reload 15");
  a_row_carry: assert property (row_carry |=> vvis_q != $past(vvis_q)
    && row_q == (vvis_q ? CVT_ROW_BLANK_START : CVT_ROW_ACTIVE_START)) // R11
    else $error("row carry load or toggle wrong");
  a_ctrl_blank: assert property (!load_n_q && ctrl_char_blank_option && ctrl_code
    |=> shift_q == 9'h000) // R16
    else $error("control code not blanked");
  a_blank_level: assert property (blank_now |=> video_o == $past(reverse_video_option)) // R17
    else $error("blanked video not at blank level");
  a_col_addr: assert property (!ext_sel_q |=> mem_addr_o[5:0] == $past({grp_q[1:0], sub_q})) // R05
    else $error("column address mismatch");

endmodule : cvt_timing_gen

// file: testbench/cvt_display_model.sv
// Display memory and character generator stand-in for the timing generator bench.
`timescale 1ns/100ps
module cvt_display_model
  import cvt_pkg::*;
(
  input wire logic clk_i,
  input wire logic [9:0] mem_addr_i,
  input wire logic [6:0] char_code_i,
  input wire logic [3:0] scan_line_i,
  input wire logic [6:0] fill_code_i,
  output logic [7:0] char_data_o,
  output logic [6:0] glyph_o
);
  // ************************************************************
  // Memory read path
  // ************************************************************
  // Every cell holds the same code with the cursor bit clear.
  // The read is registered, as a real memory answers one dot after its address.
  always_ff @(posedge clk_i) begin
    char_data_o <= {1'b0, fill_code_i ^ 7'(mem_addr_i & 10'h000)};
  end

  // The generator lights every dot on every scan line, line 15 included.
  // This way only the block itself can produce the blank spacer line.
  assign glyph_o = 7'h7f | 7'(char_code_i & 7'h00) | 7'(scan_line_i & 4'h0);
endmodule : cvt_display_model

// file: testbench/test_char_video_timing_generator.sv
// Self-checking bench for the character video timing generator.
`timescale 1ns/100ps
module test_char_video_timing_generator;
  import cvt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] wb_adr_i = 3'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic page_n = 1'b1;
  logic mid_sync = 1'b0;
  logic [9:0] ext_addr = 10'h000;
  logic [6:0] fill_code = 7'h49;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] char_data;
  logic [6:0] glyph, char_code_o;
  logic [9:0] mem_addr_o;
  logic [3:0] scan_line_o;
  logic load_clock_n_o, hsync_trigger_o, horizontal_visible_o, vertical_visible_o;
  logic hsync_o, vsync_o, comp_sync_o, comp_blank_n_o, video_o;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int n, ones;
  logic [31:0] rd, st;
  logic [3:0] sc;

  // ************************************************************
  // Clock, device and far side
  // ************************************************************
  // A 4 ns dot clock.
  always #2 clk_i = ~clk_i;

  cvt_timing_gen dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i),
    .wb_cyc_i(wb_cyc_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .display_page_select_n_i(page_n), .mid_sync_phase_i(mid_sync), .ext_addr_i(ext_addr),
    .char_data_i(char_data), .glyph_i(glyph), .mem_addr_o(mem_addr_o),
    .char_code_o(char_code_o), .scan_line_o(scan_line_o), .load_clock_n_o(load_clock_n_o),
    .hsync_trigger_o(hsync_trigger_o), .horizontal_visible_o(horizontal_visible_o),
    .vertical_visible_o(vertical_visible_o), .hsync_o(hsync_o), .vsync_o(vsync_o),
    .comp_sync_o(comp_sync_o), .comp_blank_n_o(comp_blank_n_o), .video_o(video_o));

  cvt_display_model model_u (.clk_i(clk_i), .mem_addr_i(mem_addr_o),
    .char_code_i(char_code_o), .scan_line_i(scan_line_o), .fill_code_i(fill_code),
    .char_data_o(char_data), .glyph_o(glyph));

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("mismatches %0d of %0d comparisons", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // The whole plan needs about 85000 cycles; the ceiling stays under the run budget.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 99000) begin
      num_errors++;
      finish_test();
    end
  end

  // Composite sync is watched on every dot outside reset.
  always @(negedge clk_i) begin
    if (!rst_i) check(32'(comp_sync_o), 32'(hsync_o ^ vsync_o));
  end

  // ************************************************************
  // Access and measurement tasks
  // ************************************************************
  // One classic cycle; the request stands until ack is seen high at an edge.
  task automatic wb_rw(input logic [4:0] ofs, input logic we, input logic [31:0] wd,
                       input logic [3:0] sel, output logic [31:0] data);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ofs[4:2];
    wb_dat_i <= wd;
    wb_sel_i <= sel;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    data = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (k >= 20) check(32'h0, 32'h1);
  endtask : wb_rw

  function automatic logic sig(input int w);
    case (w)
      0: sig = hsync_trigger_o;
      1: sig = horizontal_visible_o;
      2: sig = hsync_o;
      4: sig = comp_blank_n_o;
      default: sig = load_clock_n_o;
    endcase
  endfunction : sig

  // Counts dots until the chosen output shows the wanted level.
  task automatic count_until(input int w, input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk_i);
      cnt++;
    end while (sig(w) !== lvl && cnt < 2000);
  endtask : count_until

  // Counts lit dots over whole lines, from preset to preset, until the wanted scan line.
  task automatic line_ones(input logic [3:0] want, output int lit);
    int tries;
    logic [3:0] seen;
    tries = 0;
    do begin
      count_until(0, 1'b1, n);
      count_until(0, 1'b0, n);
      lit = 0;
      for (int k = 0; k < 918; k++) begin
        @(negedge clk_i);
        lit += int'(video_o === 1'b1);
        if (k == 400) seen = scan_line_o;
      end
      tries++;
    end while (seen !== want && tries < 15);
  endtask : line_ones

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, byte lanes and the unmapped hole.
    wb_rw(5'h04, 1'b0, 32'h0, 4'h0, rd); check(rd, 32'h0044_0008);
    wb_rw(5'h08, 1'b0, 32'h0, 4'h0, rd); check(rd, 32'h0800_0010);
    wb_rw(5'h00, 1'b1, 32'hffff_ff03, 4'h1, rd);
    wb_rw(5'h00, 1'b0, 32'h0, 4'h0, rd); check(rd, 32'h0000_0003);
    wb_rw(5'h10, 1'b1, 32'hffff_ffff, 4'hf, rd);
    wb_rw(5'h10, 1'b0, 32'h0, 4'h0, rd); check(rd, 32'h0);
    wb_rw(5'h00, 1'b1, 32'h0, 4'hf, rd);
    // Character clock: one low dot in nine.
    count_until(3, 1'b0, n);
    count_until(3, 1'b1, n); check(32'(n), 32'd1);
    count_until(3, 1'b0, n); check(32'(n), 32'd8);
    // Line of 102 characters; group bit 3 spans groups 8 and 9, bit 2 groups 4 to 7.
    count_until(0, 1'b1, n);
    count_until(0, 1'b0, n); check(32'(n), 32'd225);
    count_until(0, 1'b1, n); check(32'(n), 32'd693);
    count_until(1, 1'b0, n);
    count_until(1, 1'b1, n);
    count_until(1, 1'b0, n); check(32'(n), 32'd576);
    // Composite blank follows the visible span two character loads later.
    count_until(1, 1'b1, n);
    count_until(4, 1'b1, n); check(32'(n), 32'd18);
    count_until(4, 1'b0, n); check(32'(n), 32'd576);
    // Horizontal sync: start delay plus two dots, then the width.
    count_until(0, 1'b0, n);
    count_until(0, 1'b1, n);
    count_until(2, 1'b1, n); check(32'(n), 32'd10);
    count_until(2, 1'b0, n); check(32'(n), 32'd68);
    wb_rw(5'h04, 1'b1, 32'h0005_0003, 4'hf, rd);
    count_until(0, 1'b0, n);
    count_until(0, 1'b1, n);
    count_until(2, 1'b1, n); check(32'(n), 32'd5);
    count_until(2, 1'b0, n); check(32'(n), 32'd5);
    // A bus access to the display page takes over the memory address.
    ext_addr <= 10'h2a5;
    page_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    mid_sync <= 1'b1;
    n = 0;
    while (mem_addr_o !== 10'h2a5 && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(mem_addr_o), 32'h2a5);
    page_n <= 1'b1;
    mid_sync <= 1'b0;
    // Scan lines of one row: 15 first, then 0 to 11, and the row counter steps once.
    sc = 4'h0;
    for (int k = 0; k < 15 && sc !== 4'hf; k++) begin
      count_until(0, 1'b0, n);
      count_until(0, 1'b1, n);
      sc = scan_line_o;
    end
    wb_rw(5'h0c, 1'b0, 32'h0, 4'h0, st);
    for (int k = 0; k < 13; k++) begin
      if (k > 0) begin
        count_until(0, 1'b0, n);
        count_until(0, 1'b1, n);
      end
      check(32'(scan_line_o), (k == 0) ? 32'hf : 32'(k - 1));
    end
    count_until(0, 1'b0, n);
    count_until(0, 1'b1, n);
    check(32'(scan_line_o), 32'hf);
    wb_rw(5'h0c, 1'b0, 32'h0, 4'h0, rd);
    check(32'(rd[15:12]), 32'((st[15:12] + 4'h1) & 4'hf));
    check(32'(vertical_visible_o), 32'h0);
    // Video: printable code shows dots even with the control option on.
    wb_rw(5'h00, 1'b1, 32'h0000_0001, 4'hf, rd);
    line_ones(4'h0, ones); check(32'(ones > 0), 32'h1);
    fill_code <= 7'h01;
    line_ones(4'h0, ones); check(32'(ones), 32'd0);
    fill_code <= 7'h49;
    wb_rw(5'h00, 1'b1, 32'h0, 4'hf, rd);
    line_ones(4'hf, ones); check(32'(ones), 32'd0);
    // Reverse video makes blanked and spacer dots all lit.
    wb_rw(5'h00, 1'b1, 32'h0000_0002, 4'hf, rd);
    line_ones(4'hf, ones); check(32'(ones), 32'd918);
    finish_test();
  end
endmodule : test_char_video_timing_generator
